// ==== cws_defs.svh ====
// Constants for the clause wavefront scheduler
`ifndef CWS_DEFS_SVH
`define CWS_DEFS_SVH
`define CWS_ALU_CLAUSE_MAX 128
`define CWS_SLOT_CYCLES 4
`define CWS_REG_READ_LAT 8
`define CWS_SWITCH_NS 320
`define CWS_CLK_PERIOD_NS 8
`define CWS_SWITCH_CYCLES (`CWS_SWITCH_NS / `CWS_CLK_PERIOD_NS)
`define CWS_VLIW_LANES 5
`endif

// ==== cws_pkg.sv ====
// Types for the clause wavefront scheduler
package cws_pkg;
  typedef enum logic [1:0] {
    CWS_FETCH = 2'h0,
    CWS_ALU = 2'h1,
    CWS_STORE = 2'h2,
    CWS_CTRL = 2'h3
  } cws_kind_t;
  typedef enum logic [1:0] {
    CWS_IDLE = 2'h0,
    CWS_ISSUE = 2'h1,
    CWS_GAP = 2'h3
  } cws_state_t;
  typedef struct packed {
    cws_kind_t kind;
    logic localSharedMemory;
    logic fetchDep;
    logic serialDep;
  } cws_instr_t;
endpackage

// ==== cws_scheduler.sv ====
// Clause forming and wavefront scheduling for one compute unit
`timescale 1ns/10ps
`include "cws_defs.svh"
module cws_scheduler #(
  parameter int NUM_WAVES = 4,
  parameter int WID = $clog2(NUM_WAVES),
  parameter int LANES = `CWS_VLIW_LANES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Per-wavefront instruction offer
  input wire logic [NUM_WAVES-1:0] waveReady,
  input wire cws_pkg::cws_instr_t instr [NUM_WAVES],
  // Memory status
  input wire logic sharedMemBusy,
  input wire logic [NUM_WAVES-1:0] fetchPending,
  // Issue result
  output logic issueValid,
  output logic [WID-1:0] issueWave,
  output logic issueOdd,
  output logic [1:0] issueQuarter,
  output logic [LANES-1:0] laneUse,
  output logic addrOnAlu,
  output logic clauseStart,
  output logic readOperands,
  output logic [WID-1:0] readWave,
  output logic stall,
  output logic [NUM_WAVES-1:0] instrTaken
);
  localparam logic [7:0] ALU_MAX = 8'(`CWS_ALU_CLAUSE_MAX);
  localparam logic [5:0] GAP_CYC = 6'(`CWS_SWITCH_CYCLES);
  cws_pkg::cws_state_t state [2];
  cws_pkg::cws_kind_t clauseKind [2];
  logic [WID-1:0] wave [2];
  logic [7:0] opCount [2];
  logic [5:0] gapCount [2];
  logic [WID-1:0] rrPtr;
  logic [1:0] quarter;
  logic side;
  logic [NUM_WAVES-1:0] busy;
  logic slotGo;
  logic [1:0] runLen;
  // Slot counter: quarter-wavefront per unstalled cycle, side flips every 4; a stall holds it
  always_ff @(posedge clk) begin
    if (rst) begin
      quarter <= 2'h0;
      side <= 1'b0;
    end else if (!stall) begin
      quarter <= quarter + 2'h1;
      if (quarter == 2'h3) side <= ~side;
    end
  end
  // Issue starts only at quarter 0 so no instruction loses quarters
  always_ff @(posedge clk) begin
    if (rst) begin
      slotGo <= 1'b0;
    end else if (!stall) begin
      slotGo <= issueValid && quarter != 2'h3;
    end
  end
  // Quarters issued so far for the instruction in flight
  always_ff @(posedge clk) begin
    if (rst) begin
      runLen <= 2'h0;
    end else if (!stall) begin
      runLen <= (issueValid && quarter != 2'h3) ? runLen + 2'h1 : 2'h0;
    end
  end
  wire cws_pkg::cws_instr_t cur = instr[wave[side]];
  wire cws_pkg::cws_kind_t curKind = cur.kind;
  wire active = state[side] == cws_pkg::CWS_ISSUE;
  wire curReady = waveReady[wave[side]];
  wire typeChange = curKind != clauseKind[side];
  wire isCtrl = curKind == cws_pkg::CWS_CTRL;
  wire aluFull = clauseKind[side] == cws_pkg::CWS_ALU
      && opCount[side] == ALU_MAX;
  wire boundary = active && curReady && (typeChange || isCtrl || aluFull);
  wire depBlock = curKind == cws_pkg::CWS_ALU && cur.fetchDep
      && fetchPending[wave[side]];
  assign stall = active && curReady && !boundary
      && cur.localSharedMemory && sharedMemBusy;
  // Round-robin choice among free ready wavefronts
  logic [WID-1:0] pick;
  logic pickOk;
  always_comb begin
    logic [WID-1:0] idx;
    idx = '0;
    pick = '0;
    pickOk = 1'b0;
    for (int i = NUM_WAVES - 1; i >= 0; i--) begin
      idx = WID'((32'(rrPtr) + 32'(i) + 1) % NUM_WAVES);
      if (waveReady[idx] && !busy[idx] && !(instr[idx].fetchDep
          && fetchPending[idx])) begin
        pick = idx;
        pickOk = 1'b1;
      end
    end
  end
  always_comb begin
    busy = '0;
    for (int s = 0; s < 2; s++)
      if (state[s] != cws_pkg::CWS_IDLE) busy[wave[s]] = 1'b1;
  end
  // Another wavefront may cover the clause gap
  wire swapOut = boundary && pickOk;
  wire issueOk = active && curReady && !boundary && !stall && !depBlock
      && !isCtrl;
  assign issueValid = issueOk && (quarter == 2'h0 || slotGo);
  assign issueWave = wave[side];
  assign issueOdd = side;
  assign issueQuarter = quarter;
  assign clauseStart = issueValid && opCount[side] == 8'h0;
  assign instrTaken = (issueValid && quarter == 2'h3)
      ? NUM_WAVES'(1) << wave[side] : '0;
  assign addrOnAlu = issueValid
      && curKind != cws_pkg::CWS_ALU;
  // Dependent ops use one lane; others fill the VLIW word
  assign laneUse = !issueValid ? '0 : cur.serialDep ? LANES'(1) : '1;
  // Operands read for the other side while this one runs
  assign readOperands = state[~side] == cws_pkg::CWS_ISSUE;
  assign readWave = wave[~side];
  always_ff @(posedge clk) begin
    if (rst) begin
      rrPtr <= '0;
      for (int s = 0; s < 2; s++) begin
        state[s] <= cws_pkg::CWS_IDLE;
        clauseKind[s] <= cws_pkg::CWS_FETCH;
        wave[s] <= '0;
        opCount[s] <= 8'h0;
        gapCount[s] <= 6'h0;
      end
    end else begin
      for (int s = 0; s < 2; s++)
        if (state[s] == cws_pkg::CWS_GAP) begin
          if (gapCount[s] == 6'h1) state[s] <= cws_pkg::CWS_ISSUE;
          gapCount[s] <= gapCount[s] - 6'h1;
        end
      // Switch decisions only at this side's clause edge
      case (state[side])
        cws_pkg::CWS_IDLE: begin
          if (pickOk) begin
            state[side] <= cws_pkg::CWS_ISSUE;
            wave[side] <= pick;
            clauseKind[side] <= instr[pick].kind;
            opCount[side] <= 8'h0;
            rrPtr <= pick;
          end
        end
        cws_pkg::CWS_ISSUE: begin
          if (boundary) begin
            opCount[side] <= 8'h0;
            clauseKind[side] <= isCtrl ? cws_pkg::CWS_FETCH : curKind;
            if (swapOut) begin
              wave[side] <= pick;
              clauseKind[side] <= instr[pick].kind;
              rrPtr <= pick;
            end else begin
              state[side] <= cws_pkg::CWS_GAP;
              gapCount[side] <= GAP_CYC;
            end
          end else if (!curReady) begin
            state[side] <= cws_pkg::CWS_IDLE;
          end else if (issueValid && quarter == 2'h3) begin
            opCount[side] <= opCount[side] + 8'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end
  property slotFlip;
    @(posedge clk) disable iff (rst)
      (quarter == 2'h3 && !stall) |=> side != $past(side);
  endproperty
  slot_alternate_a: assert property (slotFlip)
    else $error("Side did not flip after four cycles");
  alu_limit_a: assert property (@(posedge clk) disable iff (rst)
    opCount[side] <= ALU_MAX) else $error("Arithmetic clause overran");
  ctrl_never_a: assert property (@(posedge clk) disable iff (rst)
    issueValid |-> curKind != cws_pkg::CWS_CTRL)
    else $error("Control op issued in clause");
  shmem_stall_a: assert property (@(posedge clk) disable iff (rst)
    stall |=> wave[side] == $past(wave[side]))
    else $error("Wavefront changed during stall");
  dep_wait_a: assert property (@(posedge clk) disable iff (rst)
    depBlock |-> !issueValid) else $error("Dependent clause started early");
  gap_len_a: assert property (@(posedge clk) disable iff (rst)
    (boundary && !swapOut) |=> state[$past(side)] == cws_pkg::CWS_GAP
      && gapCount[$past(side)] == GAP_CYC)
    else $error("Clause gap not started");
  mid_switch_a: assert property (@(posedge clk) disable iff (rst)
    (issueValid && !boundary) |=> wave[$past(side)] == $past(wave[side]))
    else $error("Wavefront switched mid clause");
  read_other_a: assert property (@(posedge clk) disable iff (rst)
    (active && readOperands) |-> readWave != issueWave)
    else $error("Operand read for the issuing wavefront");
  type_split_a: assert property (@(posedge clk) disable iff (rst)
    (active && curReady && typeChange) |-> !issueValid)
    else $error("Type change inside clause");
  stall_cov_c: cover property (@(posedge clk) disable iff (rst) stall);
  swap_cov_c: cover property (@(posedge clk) disable iff (rst) swapOut);
  gap_cov_c: cover property (@(posedge clk) disable iff (rst)
    boundary && !swapOut);
  full_slot_a: assert property (@(posedge clk) disable iff (rst)
    instrTaken != '0 |-> runLen == 2'h3)
    else $error("Instruction taken before four quarters");
  take_cov_c: cover property (@(posedge clk) disable iff (rst)
    instrTaken != '0);
  pair_cov_c: cover property (@(posedge clk) disable iff (rst)
    issueValid && readOperands);
endmodule // cws_scheduler

// ==== tb_cws_scheduler.sv ====
// Self-checking testbench for the clause wavefront scheduler
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] waveReady = 4'h0;
  cws_pkg::cws_instr_t instr [4];
  logic sharedMemBusy = 1'b0;
  int waited = 0;
  logic [3:0] fetchPending = 4'h0;
  logic issueValid, issueOdd, addrOnAlu, clauseStart, readOperands, stall;
  logic [1:0] issueWave, issueQuarter, readWave;
  logic [4:0] laneUse;
  logic [3:0] instrTaken;
  int failures = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  cws_scheduler dut (.clk(clk), .rst(rst), .waveReady(waveReady),
    .instr(instr), .sharedMemBusy(sharedMemBusy),
    .fetchPending(fetchPending),
    .issueValid(issueValid), .issueWave(issueWave), .issueOdd(issueOdd),
    .issueQuarter(issueQuarter), .laneUse(laneUse), .addrOnAlu(addrOnAlu),
    .clauseStart(clauseStart), .readOperands(readOperands),
    .readWave(readWave), .stall(stall), .instrTaken(instrTaken));
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic cy(); @(posedge clk); #6; endtask
  task automatic drv(); @(posedge clk); #1; endtask
  function automatic logic hit(int sel);
    case (sel)
      0: return issueValid === 1'b1;
      1: return stall === 1'b1;
      default: return (|instrTaken) === 1'b1;
    endcase
  endfunction
  task automatic wt(int sel);
    for (int i = 0; i < 200; i++) begin
      cy();
      if (hit(sel)) begin
        waited = i + 1;
        return;
      end
    end
    failures++;
    give_verdict();
  endtask
  task automatic offer(int w, cws_pkg::cws_kind_t k, logic l, logic d,
                       logic s);
    drv();
    instr[w] = '{k, l, d, s};
    waveReady[w] = 1'b1;
  endtask
  task automatic drop(); drv(); waveReady = 4'h0; endtask
  task automatic t_issue(cws_pkg::cws_kind_t k, logic s);
    offer(0, k, 1'b0, 1'b0, s);
    wt(0);
    chk("clauseStart", clauseStart, 1);
    chk("gapWait", waited >= 40, k != cws_pkg::CWS_FETCH);
    for (int q = 0; q < 4; q++) begin
      if (q > 0) cy();
      chk("issueQuarter", issueQuarter, q);
      chk("issueOdd", issueOdd, 0);
      chk("laneUse", laneUse, s ? 5'h01 : 5'h1F);
      chk("addrOnAlu", addrOnAlu, k != cws_pkg::CWS_ALU);
      chk("instrTaken", instrTaken, q == 3 ? 4'h1 : 4'h0);
    end
    drop();
  endtask
  task automatic t_stall();
    logic [1:0] q;
    offer(0, cws_pkg::CWS_ALU, 1'b1, 1'b0, 1'b0);
    sharedMemBusy = 1'b1;
    wt(1);
    q = issueQuarter;
    repeat (3) begin
      cy();
      chk("stall", stall, 1);
      chk("issueQuarter", issueQuarter, q);
    end
    drv();
    sharedMemBusy = 1'b0;
    wt(2);
    drop();
  endtask
  task automatic t_dep();
    offer(1, cws_pkg::CWS_ALU, 1'b0, 1'b1, 1'b0);
    fetchPending = 4'h2;
    repeat (20) begin
      cy();
      chk("issueValid", issueValid, 0);
    end
    drv();
    fetchPending = 4'h0;
    wt(0);
    chk("issueWave", issueWave, 1);
    wt(2);
    drv();
    fetchPending = 4'h2;
    repeat (8) begin
      cy();
      chk("issueValid", issueValid, 0);
    end
    drop();
    fetchPending = 4'h0;
  endtask
  task automatic t_ctrl();
    offer(0, cws_pkg::CWS_CTRL, 1'b0, 1'b0, 1'b0);
    repeat (12) begin
      cy();
      chk("issueValid", issueValid, 0);
    end
    drop();
  endtask
  task automatic t_pair();
    logic [3:0] seen;
    logic [1:0] odd;
    logic rd;
    seen = 4'h0;
    odd = 2'h0;
    rd = 1'b0;
    offer(2, cws_pkg::CWS_ALU, 1'b0, 1'b0, 1'b0);
    instr[3] = instr[2];
    waveReady[3] = 1'b1;
    repeat (120) begin
      cy();
      if (issueValid === 1'b1) begin
        seen[issueWave] = 1'b1;
        odd[issueOdd] = 1'b1;
        if (readOperands === 1'b1 && seen == 4'hC) begin
          rd = 1'b1;
          chk("readWave", readWave, issueWave ^ 2'h1);
        end
      end
    end
    chk("wavesIssued", seen, 4'hC);
    chk("sidesIssued", odd, 2'h3);
    chk("readOperands", rd, 1);
    drop();
  endtask
  initial begin
    for (int i = 0; i < 4; i++) instr[i] = '0;
    repeat (11) @(posedge clk);
    #6;
    chk("issueValid", issueValid, 0);
    chk("instrTaken", instrTaken, 0);
    drv();
    rst = 1'b0;
    t_issue(cws_pkg::CWS_FETCH, 1'b0);
    t_issue(cws_pkg::CWS_ALU, 1'b1);
    t_issue(cws_pkg::CWS_STORE, 1'b0);
    t_issue(cws_pkg::CWS_ALU, 1'b0);
    t_stall();
    t_dep();
    t_ctrl();
    t_pair();
    give_verdict();
  end
endmodule // tb
